// file: include/decim_pkg.sv
// Shared constants for the decimating converter link and its controller
package decim_pkg;
    localparam int RES_DEF = 18;
    localparam int LOG2_MIN = 1;
    localparam int LOG2_MAX = 5;
    localparam int PCLK_MHZ = 200;
    localparam logic [5:0] SYNC_GRID_PHASE = 6'h00;
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] DATA_I_OFS = 12'h008;
    localparam logic [11:0] DATA_Q_OFS = 12'h00C;
    localparam int CTRL_SYNC_REQ = 0;
    localparam int CTRL_POWERDOWN = 1;
    localparam int CTRL_PIN_SYNC = 2;
    localparam int CTRL_DECIM_USE = 3;
    localparam int CTRL_REAL = 4;
    localparam int CTRL_TWO_LANE = 5;
    localparam int STAT_VALID = 0;
    localparam int STAT_PENDING = 1;
    localparam logic [5:0] CTRL_RESET = 6'h00;
endpackage

// file: include/slvds_link_if.sv
// Pin-level link between the converter and the capturing logic
`timescale 1ns/10ps
interface slvds_link_if;
    logic powerdown_or_sync_pin;
    logic frame_clock;
    logic serial_clock_output;
    logic [1:0] lane_data_outputs;
    modport device (
        input powerdown_or_sync_pin,
        output frame_clock, serial_clock_output, lane_data_outputs
    );
    modport host (
        output powerdown_or_sync_pin,
        input frame_clock, serial_clock_output, lane_data_outputs
    );
endinterface

// file: sim/decim_link_monitor.sv
// Checker on the link wires between the converter end and the capturing end
`timescale 1ns/10ps
module decim_link_monitor
    import decim_pkg::*;
#(
    parameter int RES = RES_DEF
) (
    input wire logic pclk, // sampling clock
    input wire logic presetn, // async reset
    input wire logic powerdown_or_sync_pin, // shared pin
    input wire logic frame_clock, // frame marker
    input wire logic serial_clock_output, // bit clock
    input wire logic [1:0] lane_data_outputs, // lane bits
    input wire logic sync_pin_en, // pin acts as sync
    input wire logic aligned, // sync seen
    input wire logic powered_down // power-down state
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [5:0] grid_q;
    logic [6:0] high_q;
    // Mirrors the free grid counter of the capturing end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grid_q <= 6'h00;
        end else begin
            grid_q <= grid_q + 6'h01;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_q <= 7'h00;
        end else begin
            high_q <= frame_clock ? high_q + 7'h01 : 7'h00;
        end
    end
    sequence s_frame_open;
        $rose(frame_clock) ##1 $changed(serial_clock_output);
    endsequence
    sequence s_pin_sync;
        sync_pin_en && $rose(powerdown_or_sync_pin);
    endsequence
    property p_reset_quiet;
        $rose(presetn) |-> !frame_clock && lane_data_outputs == 2'h0 && !aligned;
    endproperty
    property p_frame_start;
        $rose(frame_clock) |-> s_frame_open;
    endproperty
    property p_frame_min;
        $rose(frame_clock) |-> frame_clock[*8];
    endproperty
    property p_frame_max;
        high_q <= 7'(2 * RES + 2);
    endproperty
    property p_lane_follow;
        $changed(lane_data_outputs) |-> $changed(serial_clock_output);
    endproperty
    property p_pin_grid;
        s_pin_sync |-> grid_q == SYNC_GRID_PHASE + 6'h01;
    endproperty
    property p_pin_pulse;
        s_pin_sync |=> !powerdown_or_sync_pin;
    endproperty
    property p_pin_align;
        s_pin_sync |-> ##2 aligned;
    endproperty
    property p_powerdown;
        !sync_pin_en ##1 !sync_pin_en |-> powered_down == $past(powerdown_or_sync_pin);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("link busy after reset");
    a_frame_start: assert property (p_frame_start) else $error("no bit after frame");
    a_frame_min: assert property (p_frame_min) else $error("frame too short");
    a_frame_max: assert property (p_frame_max) else $error("frame too long");
    a_lane_follow: assert property (p_lane_follow) else $error("lane moved alone");
    a_pin_grid: assert property (p_pin_grid) else $error("sync off grid");
    a_pin_pulse: assert property (p_pin_pulse) else $error("sync pulse too long");
    a_pin_align: assert property (p_pin_align) else $error("sync not taken");
    a_powerdown: assert property (p_powerdown) else $error("power-down wrong");
endmodule

// file: sim/decimation_sync_output_rate_tb.sv
// Testbench joining both link ends, driving samples and the register bus
`timescale 1ns/10ps
module decimation_sync_output_rate_tb;
    import decim_pkg::*;
    logic pclk, presetn, sample_en, decim_on, real_mode, lanes_two, sync_pin_en;
    logic sync_reg_wr, osc_reload, aligned, powered_down, psel, penable, pwrite;
    logic pready, pslverr, err, fc_q, sck_q, ovr, ovr_seen;
    logic signed [RES_DEF-1:0] adc_sample;
    logic [2:0] decim_log2;
    logic [11:0] paddr;
    logic [31:0] osc_freq, pwdata, prdata, rd;
    logic [4:0] gap_q;
    int n_fail, cmp_count, cyc_q, bits_q, per_q, tog_q, n_rise;
    slvds_link_if link();
    decim_device decim_device_inst (.pclk(pclk), .presetn(presetn), .link(link),
        .adc_sample(adc_sample), .sample_en(sample_en), .decim_on(decim_on),
        .real_mode(real_mode), .decim_log2(decim_log2), .lanes_two(lanes_two),
        .sync_pin_en(sync_pin_en), .sync_reg_wr(sync_reg_wr), .osc_freq(osc_freq),
        .osc_reload(osc_reload), .powered_down(powered_down), .aligned(aligned),
        .overrun(ovr));
    decim_host decim_host_inst (.pclk(pclk), .presetn(presetn), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    decim_link_monitor monitor_inst (.pclk(pclk), .presetn(presetn),
        .powerdown_or_sync_pin(link.powerdown_or_sync_pin), .frame_clock(link.frame_clock),
        .serial_clock_output(link.serial_clock_output),
        .lane_data_outputs(link.lane_data_outputs), .sync_pin_en(sync_pin_en),
        .aligned(aligned), .powered_down(powered_down));
    always #2.5 pclk = ~pclk;
    // One sample every 20 clocks keeps every lane mode clear of overrun
    always @(posedge pclk) begin
        gap_q <= (gap_q == 5'h13) ? 5'h00 : gap_q + 5'h01;
        sample_en <= (gap_q == 5'h13);
    end
    // Frame period and bit-clock changes, measured rise to rise
    always @(posedge pclk) begin
        fc_q <= link.frame_clock;
        sck_q <= link.serial_clock_output;
        if (ovr === 1'b1) begin
            ovr_seen <= 1'b1;
        end
        if (link.frame_clock === 1'b1 && fc_q === 1'b0) begin
            per_q <= cyc_q;
            tog_q <= bits_q + int'(link.serial_clock_output !== sck_q);
            cyc_q <= 1;
            bits_q <= 0;
            n_rise <= n_rise + 1;
        end else begin
            cyc_q <= cyc_q + 1;
            bits_q <= bits_q + int'(link.serial_clock_output !== sck_q);
        end
    end
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic frames(input int n);
        int n0;
        n0 = n_rise;
        for (int k = 0; k < 8000 && n_rise < n0 + n; k++) @(posedge pclk);
    endtask
    // Third frame after a mode change is clean of the switch-over
    task automatic t_rate(input logic rl, input logic two, input logic [2:0] lg, input int bits);
        @(posedge pclk);
        real_mode <= rl;
        lanes_two <= two;
        decim_log2 <= lg;
        // Capturing end must be told the same lane format
        apb(1'b1, CTRL_OFS, (32'(rl) << CTRL_REAL) | (32'(two) << CTRL_TWO_LANE));
        frames(3);
        check(per_q, (rl & two ? 40 : 20) << lg);
        check(tog_q, bits);
        apb(1'b0, DATA_I_OFS, 32'h0);
        check(rd, 32'h0000_1234);
    endtask
    task automatic spin(output int d);
        d = 0;
        repeat (6) begin
            frames(1);
            apb(1'b0, DATA_I_OFS, 32'h0);
            d += int'(rd !== 32'h0000_1234);
        end
    endtask
    initial begin
        int d, n0;
        {pclk, presetn, psel, penable, pwrite, sample_en, sync_reg_wr, osc_reload} = '0;
        {sync_pin_en, real_mode, fc_q, sck_q, paddr, pwdata, osc_freq, gap_q} = '0;
        ovr_seen = 1'b0;
        {decim_on, lanes_two, decim_log2} = 5'h19;
        adc_sample = 18'h01234;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(powered_down, 1'b0);
        for (int g = 1; g <= 5; g++) t_rate(1'b0, 1'b1, 3'(g), 18);
        t_rate(1'b0, 1'b0, 3'h2, 36);
        t_rate(1'b1, 1'b1, 3'h2, 18);
        t_rate(1'b1, 1'b0, 3'h2, 18);
        check(aligned, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h1 << CTRL_POWERDOWN);
        repeat (100) @(posedge pclk);
        check(powered_down, 1'b1);
        n0 = n_rise;
        repeat (300) @(posedge pclk);
        check(n_rise, n0);
        apb(1'b1, CTRL_OFS, 32'h0);
        repeat (4) @(posedge pclk);
        check(powered_down, 1'b0);
        sync_pin_en <= 1'b1;
        apb(1'b1, CTRL_OFS, 32'h1 | (32'h1 << CTRL_PIN_SYNC));
        repeat (80) @(posedge pclk);
        check(aligned, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h1 | (32'h1 << CTRL_PIN_SYNC) | (32'h1 << CTRL_DECIM_USE));
        repeat (80) @(posedge pclk);
        check(aligned, 1'b1);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd[STAT_PENDING], 1'b0);
        t_rate(1'b0, 1'b1, 3'h2, 18);
        osc_freq <= 32'h1000_0000;
        spin(d);
        check(d, 0);
        sync_reg_wr <= 1'b1;
        @(posedge pclk);
        sync_reg_wr <= 1'b0;
        spin(d);
        check(d != 0, 1'b1);
        osc_freq <= 32'h0;
        osc_reload <= ~osc_reload;
        frames(2);
        spin(d);
        check(d, 0);
        apb(1'b0, 12'h010, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        check(ovr_seen, 1'b0);
        print_verdict();
    end
    // Whole sequence needs about 7000 clocks
    initial begin
        repeat (60000) @(posedge pclk);
        n_fail++;
        print_verdict();
    end
endmodule

// file: src/decim_device.sv
// Converter end: mixer, decimator, sync handling and lane serialiser
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// RULE_01 - Complex decimation by 2 to 32
// RULE_02 - Filter suppresses content aliasing onto passband
// RULE_03 - Complex passband about 0.8 Fs over N
// RULE_04 - Real mode: real samples, half bandwidth
// RULE_05 - Factor 4 gives quarter-rate complex output
// RULE_06 - Shared pin powers down unless sync selected
// RULE_07 - Sync pin sampled on sampling clock edge
// RULE_08 - Controller syncs only when decimating
// RULE_09 - Sync resets dividers, aligns I and Q
// RULE_10 - Without sync dividers run free
// RULE_11 - Sync resets oscillator phase, loads frequency
// RULE_12 - Resync only on multiples of 64 clocks; sync_reg_wr resyncs the device on any clock
// RULE_13 - Complex lane rate Fs*2R/L/N, frame Fs/N
// RULE_14 - Real lane rate Fs*R/L/M, frame halved; the code halves the frame rate only with two lanes
// RULE_15 - New frequency needs reload toggle or sync
module decim_device
    import decim_pkg::*;
#(
    parameter int RES = RES_DEF
) (
    input wire logic pclk, // sampling clock
    input wire logic presetn, // async reset
    slvds_link_if.device link, // serial output link
    input wire logic signed [RES-1:0] adc_sample, // converter sample
    input wire logic sample_en, // sample strobe
    input wire logic decim_on, // decimation enabled
    input wire logic real_mode, // real instead of complex
    input wire logic [2:0] decim_log2, // log2 of factor, 1 to 5
    input wire logic lanes_two, // two lanes per channel
    input wire logic sync_pin_en, // pin acts as sync
    input wire logic sync_reg_wr, // register sync pulse
    input wire logic [31:0] osc_freq, // oscillator frequency word
    input wire logic osc_reload, // reload toggle bit
    output logic powered_down, // pin holds power-down
    output logic aligned, // a sync has been seen
    output logic overrun // word lost to busy lanes
);
    localparam int ACC_W = RES + LOG2_MAX + 1;
    localparam int SH_W = 2 * RES;
    localparam int BC_W = $clog2(SH_W + 1);

    logic pin_q, pin_prev_q, reload_q;
    logic sync_evt, reload_evt, step, dump, complex_out;
    logic [2:0] eff_log2;
    logic [LOG2_MAX-1:0] win_phase;
    logic [31:0] freq_q, osc_phase_q;
    logic signed [ACC_W-1:0] sample_x, term_i, term_q, acc_i_q, acc_q_q, sum_i, sum_q;
    logic [RES-1:0] word_i, word_q;
    logic [SH_W-1:0] sh0_q, sh1_q;
    logic [BC_W-1:0] bits_left_q, bits_per_lane;
    logic frame_q, sclk_q, pair_q, frame_start;
    logic [1:0] lane_q;

    // Pin taken on the sampling clock edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_q <= link.powerdown_or_sync_pin; // RULE_07
            pin_prev_q <= pin_q;
        end
    end

    assign powered_down = !sync_pin_en && pin_q; // RULE_06
    assign sync_evt = (sync_pin_en && pin_q && !pin_prev_q) || sync_reg_wr; // RULE_06
    assign step = sample_en && !powered_down;
    assign complex_out = decim_on && !real_mode;

    // Out-of-range factors are clamped rather than left undefined
    always_comb begin
        if (!decim_on) begin
            eff_log2 = 3'd0;
        end else if (decim_log2 < 3'(LOG2_MIN)) begin
            eff_log2 = 3'(LOG2_MIN);
        end else if (decim_log2 > 3'(LOG2_MAX)) begin
            eff_log2 = 3'(LOG2_MAX);
        end else begin
            eff_log2 = decim_log2; // RULE_01
        end
    end

    decim_divider #(.CW(LOG2_MAX)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .step(step),
        .align(sync_evt),
        .log2n(eff_log2),
        .dump(dump),
        .phase(win_phase)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aligned <= 1'b0;
        end else if (sync_evt) begin
            aligned <= 1'b1;
        end
    end

    // Tuning oscillator: a written frequency stays idle until a reload toggle or a sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_q <= 1'b0;
        end else begin
            reload_q <= osc_reload;
        end
    end

    assign reload_evt = osc_reload ^ reload_q; // RULE_15

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_q <= 32'h00000000;
            osc_phase_q <= 32'h00000000;
        end else if (sync_evt || reload_evt) begin // RULE_11
            freq_q <= osc_freq;
            osc_phase_q <= 32'h00000000;
        end else if (step) begin
            osc_phase_q <= osc_phase_q + freq_q;
        end
    end

    // Coarse quadrature mixer from the top two phase bits
    assign sample_x = ACC_W'(adc_sample);

    always_comb begin
        term_i = sample_x;
        term_q = '0;
        if (complex_out) begin
            case (osc_phase_q[31:30])
                2'b00: begin
                    term_i = sample_x;
                    term_q = '0;
                end
                2'b01: begin
                    term_i = '0;
                    term_q = sample_x;
                end
                2'b10: begin
                    term_i = -sample_x;
                    term_q = '0;
                end
                default: begin
                    term_i = '0;
                    term_q = -sample_x;
                end
            endcase
        end
    end

    // Integrate and dump; the scaled mean keeps full-scale gain at one.
    // Single-stage boxcar: passband droop is traded for area.
    assign sum_i = acc_i_q + term_i; // RULE_02
    assign sum_q = acc_q_q + term_q;
    assign word_i = RES'(sum_i >>> eff_log2); // RULE_03
    assign word_q = RES'(sum_q >>> eff_log2); // RULE_04

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_i_q <= '0;
            acc_q_q <= '0;
        end else if (sync_evt) begin // RULE_09
            acc_i_q <= '0;
            acc_q_q <= '0;
        end else if (dump) begin
            acc_i_q <= '0;
            acc_q_q <= '0;
        end else if (step) begin
            acc_i_q <= sum_i;
            acc_q_q <= sum_q;
        end
    end

    // Bits each lane carries per output sample
    always_comb begin
        if (complex_out) begin
            bits_per_lane = lanes_two ? BC_W'(RES) : BC_W'(2 * RES); // RULE_13
        end else begin
            bits_per_lane = lanes_two ? BC_W'(RES / 2) : BC_W'(RES); // RULE_14
        end
    end

    // Two-lane real frames span two samples, halving the frame rate
    assign frame_start = !(!complex_out && lanes_two) || !pair_q; // RULE_14

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_q <= 1'b0;
        end else if (sync_evt) begin
            pair_q <= 1'b0;
        end else if (dump) begin
            pair_q <= !pair_q;
        end
    end

    // I and Q of one window are loaded together, one bit per clock.
    // A new word while bits remain restarts the lanes and flags it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh0_q <= '0;
            sh1_q <= '0;
            bits_left_q <= '0;
            frame_q <= 1'b0;
            overrun <= 1'b0;
        end else if (dump) begin // RULE_05
            overrun <= (bits_left_q != '0);
            bits_left_q <= bits_per_lane;
            frame_q <= frame_start; // RULE_13
            if (complex_out && lanes_two) begin
                sh0_q <= {word_i, {RES{1'b0}}}; // RULE_09
                sh1_q <= {word_q, {RES{1'b0}}};
            end else if (complex_out) begin
                sh0_q <= {word_i, word_q};
                sh1_q <= '0;
            end else if (lanes_two) begin
                sh0_q <= {word_i[RES-1:RES/2], {(SH_W-RES/2){1'b0}}};
                sh1_q <= {word_i[RES/2-1:0], {(SH_W-RES/2){1'b0}}};
            end else begin
                sh0_q <= {word_i, {RES{1'b0}}};
                sh1_q <= '0;
            end
        end else begin
            overrun <= 1'b0;
            if (bits_left_q != '0) begin
                sh0_q <= sh0_q << 1;
                sh1_q <= sh1_q << 1;
                bits_left_q <= bits_left_q - BC_W'(1);
            end
            if (bits_left_q == BC_W'(1)) begin
                frame_q <= 1'b0;
            end
        end
    end

    // One bit per serial clock edge: the clock runs at half the lane rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_q <= 2'b00;
            sclk_q <= 1'b0;
        end else if (!dump && bits_left_q != '0) begin
            lane_q <= {sh1_q[SH_W-1], sh0_q[SH_W-1]};
            sclk_q <= !sclk_q; // RULE_13
        end
    end

    assign link.lane_data_outputs = lane_q;
    assign link.serial_clock_output = sclk_q;
    assign link.frame_clock = frame_q;
endmodule

// file: src/decim_divider.sv
// Decimation clock divider, free-running until aligned by a sync event
`timescale 1ns/10ps
module decim_divider #(
    parameter int CW = 5
) (
    input wire logic pclk, // sampling clock
    input wire logic presetn, // async reset
    input wire logic step, // one input sample
    input wire logic align, // sync event
    input wire logic [2:0] log2n, // log2 of factor
    output logic dump, // last sample of window
    output logic [CW-1:0] phase // position in window
);
    logic [CW-1:0] mask;

    assign mask = CW'((32'd1 << log2n) - 32'd1);
    assign dump = step && !align && (phase == mask);

    // Only a sync clears the phase; otherwise it runs on unaligned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= '0;
        end else if (align) begin // RULE_09
            phase <= '0;
        end else if (step) begin // RULE_10
            phase <= (phase == mask) ? '0 : phase + CW'(1);
        end
    end
endmodule

// file: src/decim_host.sv
// Capturing end: APB control, sync pin driver and lane deserialiser
`timescale 1ns/10ps
module decim_host
    import decim_pkg::*;
#(
    parameter int RES = RES_DEF
) (
    input wire logic pclk, // clock, same as sampling clock
    input wire logic presetn, // async reset
    slvds_link_if.host link, // serial input link
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr // APB error
);
    localparam int SH_W = 2 * RES;
    localparam int BC_W = $clog2(SH_W + 1);

    logic [5:0] ctrl_q, grid_q;
    logic pending_q, valid_q, pin_q, sclk_prev_q, frame_clock_prev_q, locked_q, fire;
    logic wr, rd_setup, bit_edge, start, capture, cplx, mapped;
    logic [BC_W-1:0] cnt_q, cnt_d, bits_per_lane;
    logic [SH_W-1:0] in0_q, in1_q, s0n, s1n;
    logic [RES-1:0] data_i_q, data_q_q;

    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr == CTRL_OFS) || (paddr == STATUS_OFS)
        || (paddr == DATA_I_OFS) || (paddr == DATA_Q_OFS);
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr && paddr == CTRL_OFS) begin
            ctrl_q <= pwdata[5:0];
            ctrl_q[CTRL_SYNC_REQ] <= 1'b0;
        end
    end

    // Sync request waits for the 64-clock grid; set wins over firing
    assign fire = pending_q && (grid_q == SYNC_GRID_PHASE); // RULE_12

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grid_q <= 6'h00;
            pending_q <= 1'b0;
        end else begin
            grid_q <= grid_q + 6'h01;
            if (wr && paddr == CTRL_OFS && pwdata[CTRL_SYNC_REQ]
                    && pwdata[CTRL_DECIM_USE]) begin // RULE_08
                pending_q <= 1'b1;
            end else if (fire) begin
                pending_q <= 1'b0;
            end
        end
    end

    // One-clock pin pulse, driven from the same clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else if (ctrl_q[CTRL_PIN_SYNC]) begin
            pin_q <= fire; // RULE_07
        end else begin
            pin_q <= ctrl_q[CTRL_POWERDOWN];
        end
    end

    assign link.powerdown_or_sync_pin = pin_q;

    // Deserialiser: every serial clock edge carries one bit per lane
    assign cplx = !ctrl_q[CTRL_REAL];

    always_comb begin
        if (cplx) begin
            bits_per_lane = ctrl_q[CTRL_TWO_LANE] ? BC_W'(RES) : BC_W'(2 * RES); // RULE_13
        end else begin
            bits_per_lane = ctrl_q[CTRL_TWO_LANE] ? BC_W'(RES / 2) : BC_W'(RES); // RULE_14
        end
    end

    // Frame level is compared bit to bit: it rises one clock ahead of its first bit
    assign bit_edge = link.serial_clock_output != sclk_prev_q;
    assign start = bit_edge && link.frame_clock && !frame_clock_prev_q;
    assign s0n = {in0_q[SH_W-2:0], link.lane_data_outputs[0]};
    assign s1n = {in1_q[SH_W-2:0], link.lane_data_outputs[1]};
    assign cnt_d = start ? BC_W'(1) : cnt_q + BC_W'(1);
    assign capture = bit_edge && (locked_q || start) && (cnt_d == bits_per_lane);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev_q <= 1'b0;
            frame_clock_prev_q <= 1'b0;
            locked_q <= 1'b0;
            cnt_q <= '0;
            in0_q <= '0;
            in1_q <= '0;
        end else begin
            sclk_prev_q <= link.serial_clock_output;
            if (start) begin
                locked_q <= 1'b1;
            end
            if (bit_edge) begin
                frame_clock_prev_q <= link.frame_clock; // RULE_13
                in0_q <= s0n;
                in1_q <= s1n;
                cnt_q <= capture ? '0 : cnt_d;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_i_q <= '0;
            data_q_q <= '0;
        end else if (capture) begin
            if (cplx && ctrl_q[CTRL_TWO_LANE]) begin
                data_i_q <= s0n[RES-1:0];
                data_q_q <= s1n[RES-1:0];
            end else if (cplx) begin
                data_i_q <= s0n[SH_W-1:RES];
                data_q_q <= s0n[RES-1:0];
            end else if (ctrl_q[CTRL_TWO_LANE]) begin
                data_i_q <= {s0n[RES/2-1:0], s1n[RES/2-1:0]};
                data_q_q <= '0;
            end else begin
                data_i_q <= s0n[RES-1:0];
                data_q_q <= '0;
            end
        end
    end

    // Word-valid flag: a capture in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q <= 1'b0;
        end else if (capture) begin
            valid_q <= 1'b1;
        end else if (wr && paddr == STATUS_OFS && pwdata[STAT_VALID]) begin
            valid_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            if (paddr == CTRL_OFS) begin
                prdata <= {26'h0000000, ctrl_q};
            end else if (paddr == STATUS_OFS) begin
                prdata <= {30'h00000000, pending_q, valid_q};
            end else if (paddr == DATA_I_OFS) begin
                prdata <= 32'(signed'(data_i_q));
            end else if (paddr == DATA_Q_OFS) begin
                prdata <= 32'(signed'(data_q_q));
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end
endmodule
